// *** core/tsc_channel.sv ***
// Notes on behaviour
// - Length code N from 3 to 15 gives characters of N+1 bits.
// - Short characters: upper memory bits ignored on send, written zero on receive.
// - Reverse bit set sends most significant bit first, else least first.
// - Protocol select 11 is transparent; other codes leave the channel idle (here echo mode still copies receive data to txd).
// - Overrun, full buffer or hunt closes receive buffer, flags event, moves on.
// - Receive descriptor with empty set is device-owned; cleared ones are never reused.
// - Wrap bit returns to table base, otherwise next descriptor.
// - Interrupt bit set: receive event flagged when the buffer closes.
// - Continuous receive keeps empty set, except after a reception error.
// - Ready bit hands descriptor over; device clears it when sent or on error.
// - Last-in-frame needs resync before next buffer; else next follows at once.
// - Continuous transmit keeps ready set, except after a transmit error.
// - Interrupt bit set: transmit done or transmit error event on service.
// - Underrun sets the descriptor error status bit.
// - Events clear by writing ones; request holds while unmasked events remain.
// - Event bits: error 4, out of buffers 2, transmit 1, receive 0.
// - Done flags at final char start for last-in-frame, else at holding load.
// - Mask mirrors events; one enables, zero masks, clear at reset.
//
// Our own choices: strobed register access and the placing of the registers.
module tsc_channel
  import tsc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [9:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        sclk_i,
  input  wire logic        sync_n_i,
  input  wire logic        rxd_i,
  input  wire logic        mem_wait_i,
  output logic             txd_o,
  output logic             irq_o
);
  `include "tsc_defs.svh"

  tsc_state_t  st_r;
  tsc_state_t  st_nxt;
  logic [15:0] mem_q [0:`TSC_MEM_WORDS-1];
  logic        mem_we;
  logic [5:0]  mem_wa;
  logic [15:0] mem_wd;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        sync_fall;
  logic        rxd_s;

  tsc_pin_sync u_pins (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .sclk_i      (sclk_i),
    .sync_n_i    (sync_n_i),
    .rxd_i       (rxd_i),
    .sclk_rise_o (sclk_rise),
    .sclk_fall_o (sclk_fall),
    .sync_fall_o (sync_fall),
    .rxd_o       (rxd_s)
  );

  // Decoded mode fields
  logic [3:0]  char_length_code;
  logic        wide;
  logic        msbf;
  tsc_diag_t   diag;
  logic        tx_en;
  logic        rx_en;
  logic [15:0] char_mask;
  logic [15:0] step;
  assign char_length_code      = st_r.mode[`TSC_MD_CHAR_LENGTH_CODE +: 4];
  assign wide      = char_length_code > `TSC_CHAR_LENGTH_CODE_BYTE_MAX;
  assign msbf      = st_r.mode[`TSC_MD_MSB_FIRST_SELECT];
  assign diag      = tsc_diag_t'(st_r.mode[`TSC_MD_DM +: 2]);
  assign tx_en     = st_r.mode[`TSC_MD_TEN]
                     && st_r.mode[`TSC_MD_SM +: 2] == `TSC_SM_TRANSP;
  assign rx_en     = st_r.mode[`TSC_MD_REN]
                     && st_r.mode[`TSC_MD_SM +: 2] == `TSC_SM_TRANSP;
  assign char_mask = `TSC_ONES16 >> (`TSC_CHAR_LENGTH_CODE_MAX - char_length_code);
  assign step      = wide ? `TSC_STEP_WORD : `TSC_STEP_BYTE;

  // Software owns the memory port in any cycle it touches the window
  logic sw_mem;
  logic sw_bd;
  logic mem_busy;
  assign sw_mem   = (wr_i || rd_i) && addr_i[9:8] == `TSC_MEM_SEL;
  assign sw_bd    = addr_i[9:7] == `TSC_BD_SEL;
  assign mem_busy = mem_wait_i || sw_mem;

  // Descriptor indices and buffer addresses
  logic [2:0]  tb;
  logic [2:0]  rb;
  logic [6:0]  tx_addr;
  logic [6:0]  rx_addr;
  logic [15:0] tx_word;
  logic [15:0] rx_old;
  logic [15:0] tx_char;
  assign tb      = {`TSC_TX_TABLE, st_r.tx_cur};
  assign rb      = {`TSC_RX_TABLE, st_r.rx_cur};
  assign tx_addr = st_r.bd_ptr[tb] + st_r.tx_cnt[6:0];
  assign rx_addr = st_r.bd_ptr[rb] + st_r.rx_cnt[6:0];
  assign tx_word = mem_q[tx_addr[6:1]];
  assign rx_old  = mem_q[rx_addr[6:1]];
  // Even byte is the high half of a word; unused upper bits never reach the line
  assign tx_char = (wide ? tx_word
                         : {8'h00, tx_addr[0] ? tx_word[7:0] : tx_word[15:8]})
                   & char_mask;

  // Next-state logic for the whole channel
  always_comb
  begin
    logic        tx_ok;
    logic        tx_err;
    logic        rx_ok;
    logic        rx_err;
    logic        tx_need;
    logic        underrun;
    logic        nbit;
    logic [3:0]  nb;
    logic [15:0] tcnt;
    logic [15:0] rcnt;
    tx_ok    = 1'b0;
    tx_err   = 1'b0;
    rx_ok    = 1'b0;
    rx_err   = 1'b0;
    tx_need  = 1'b0;
    underrun = 1'b0;
    nbit     = 1'b0;
    nb       = st_r.tx_bit + 4'h1;
    tcnt     = st_r.tx_cnt + step;
    rcnt     = st_r.rx_cnt + step;
    st_nxt   = st_r;
    mem_we   = 1'b0;
    mem_wa   = addr_i[7:2];
    mem_wd   = wdata_i[15:0];

    // Software writes first so that hardware updates below win a clash
    if (wr_i)
    begin
      case (addr_i)
        `TSC_OFS_MODE:  st_nxt.mode  = wdata_i[15:0] & `TSC_MODE_WMASK;
        `TSC_OFS_EVT:   st_nxt.evt   = st_r.evt & ~wdata_i[7:0];
        `TSC_OFS_MASK:  st_nxt.mask  = wdata_i[7:0] & `TSC_EV_WMASK;
        `TSC_OFS_MRBL:  st_nxt.mrbl  = wdata_i[15:0];
        `TSC_OFS_RECEIVE_TABLE_BASE: st_nxt.receive_table_base = wdata_i[1:0];
        `TSC_OFS_TRANSMIT_TABLE_BASE: st_nxt.transmit_table_base = wdata_i[1:0];
        default:
        begin
          if (sw_bd && addr_i[3:2] == `TSC_FLD_ST)
            st_nxt.bd_st[addr_i[6:4]] = wdata_i[15:0];
          else if (sw_bd && addr_i[3:2] == `TSC_FLD_LEN)
            st_nxt.bd_len[addr_i[6:4]] = wdata_i[15:0];
          else if (sw_bd && addr_i[3:2] == `TSC_FLD_PTR)
            st_nxt.bd_ptr[addr_i[6:4]] = wdata_i[6:0];
          mem_we = sw_mem;
        end
      endcase
    end

    // Transmitter: descriptor polling, holding register load, shifter
    if (!tx_en)
    begin
      st_nxt.tx_st    = TSC_TX_OFF;
      st_nxt.tx_act   = 1'b0;
      st_nxt.tx_hv    = 1'b0;
      st_nxt.tx_hlast = 1'b0;
      st_nxt.tx_shact = 1'b0;
      st_nxt.tx_line  = 1'b1;
    end
    else
    begin
      case (st_r.tx_st)
        TSC_TX_OFF:  st_nxt.tx_st = TSC_TX_WAIT;
        TSC_TX_WAIT:
        begin
          // The final char of a frame keeps shifting while sync is awaited
          if (sync_fall)
            st_nxt.tx_st = TSC_TX_RUN;
          if (sclk_fall && st_r.tx_shact && st_r.tx_bit != char_length_code)
          begin
            st_nxt.tx_bit  = nb;
            st_nxt.tx_line = st_r.tx_sh[msbf ? char_length_code - nb : nb];
          end
          else if (sclk_fall)
          begin
            st_nxt.tx_shact = 1'b0;
            st_nxt.tx_line  = 1'b1;
          end
        end
        TSC_TX_HALT:
        begin
          if (wr_i && addr_i == `TSC_OFS_CMD && wdata_i[`TSC_CMD_RESTART])
            st_nxt.tx_st = TSC_TX_RUN;
        end
        TSC_TX_RUN:
        begin
          // A character boundary with nothing in holding mid-buffer is an underrun
          tx_need  = sclk_fall && !(st_r.tx_shact && st_r.tx_bit != char_length_code);
          underrun = tx_need && !st_r.tx_hv && st_r.tx_act
                     && st_r.tx_cnt != '0 && st_r.tx_cnt < st_r.bd_len[tb];
          if (!st_r.tx_act)
          begin
            if (st_r.bd_st[tb][`TSC_BD_OWN])
            begin
              st_nxt.tx_act  = 1'b1;
              st_nxt.tx_cnt  = '0;
              st_nxt.tx_last = st_r.bd_st[tb][`TSC_BD_L];
            end
          end
          else if (!st_r.tx_hv && !mem_busy && !underrun
                   && st_r.tx_cnt < st_r.bd_len[tb])
          begin
            st_nxt.tx_hold = tx_char;
            st_nxt.tx_hv   = 1'b1;
            st_nxt.tx_cnt  = tcnt;
            if (tcnt >= st_r.bd_len[tb])
            begin
              if (st_r.tx_last)
                st_nxt.tx_hlast = 1'b1;
              else
                tx_ok = 1'b1;
            end
          end
          if (sclk_fall && st_r.tx_shact && st_r.tx_bit != char_length_code)
          begin
            st_nxt.tx_bit  = nb;
            st_nxt.tx_line = st_r.tx_sh[msbf ? char_length_code - nb : nb];
          end
          else if (tx_need && st_r.tx_hv)
          begin
            st_nxt.tx_sh    = st_r.tx_hold;
            st_nxt.tx_hv    = 1'b0;
            st_nxt.tx_bit   = '0;
            st_nxt.tx_shact = 1'b1;
            st_nxt.tx_line  = st_r.tx_hold[msbf ? char_length_code : 4'h0];
            if (st_r.tx_hlast)
            begin
              tx_ok           = 1'b1;
              st_nxt.tx_hlast = 1'b0;
              st_nxt.tx_st    = TSC_TX_WAIT;
            end
          end
          else if (underrun)
          begin
            tx_err          = 1'b1;
            st_nxt.tx_shact = 1'b0;
            st_nxt.tx_line  = 1'b1;
            st_nxt.tx_st    = TSC_TX_HALT;
          end
          else if (tx_need)
          begin
            // Idle ones between buffers
            st_nxt.tx_shact = 1'b0;
            st_nxt.tx_line  = 1'b1;
          end
        end
        default: st_nxt.tx_st = TSC_TX_OFF;
      endcase
    end

    // Closing a transmit descriptor
    if (tx_ok || tx_err)
    begin
      st_nxt.tx_act = 1'b0;
      if (!st_r.bd_st[tb][`TSC_BD_CM] || tx_err)
        st_nxt.bd_st[tb][`TSC_BD_OWN] = 1'b0;
      if (tx_err)
        st_nxt.bd_st[tb][`TSC_BD_ERR] = 1'b1;
      if (st_r.bd_st[tb][`TSC_BD_I] && tx_ok)
        st_nxt.evt[`TSC_EV_TX] = 1'b1;
      if (st_r.bd_st[tb][`TSC_BD_I] && tx_err)
        st_nxt.evt[`TSC_EV_TXE] = 1'b1;
      st_nxt.tx_cur = st_r.bd_st[tb][`TSC_BD_W] ? st_r.transmit_table_base
                                                : st_r.tx_cur + 2'h1;
    end

    // Receiver: holding register drains to memory
    if (st_r.rx_hv && !mem_busy)
    begin
      if (!st_r.rx_act)
      begin
        if (st_r.bd_st[rb][`TSC_BD_OWN])
        begin
          st_nxt.rx_act = 1'b1;
          st_nxt.rx_cnt = '0;
        end
        else
        begin
          st_nxt.evt[`TSC_EV_BSY] = 1'b1;
          st_nxt.rx_hv            = 1'b0;
          st_nxt.rx_ovf           = 1'b0;
        end
      end
      else
      begin
        mem_we        = 1'b1;
        mem_wa        = rx_addr[6:1];
        mem_wd        = wide ? st_r.rx_hold
                      : rx_addr[0] ? {rx_old[15:8], st_r.rx_hold[7:0]}
                                   : {st_r.rx_hold[7:0], rx_old[7:0]};
        st_nxt.rx_cnt = rcnt;
        st_nxt.rx_hv  = 1'b0;
        if (st_r.rx_ovf)
          rx_err = 1'b1;
        else if (rcnt >= st_r.mrbl)
          rx_ok = 1'b1;
      end
    end

    // Hunt drops sync and closes a buffer that holds data
    if (wr_i && addr_i == `TSC_OFS_CMD && wdata_i[`TSC_CMD_HUNT])
    begin
      st_nxt.rx_sync = 1'b0;
      if (st_r.rx_act && st_r.rx_cnt != '0 && !rx_err && !rx_ok)
        rx_ok = 1'b1;
    end
    else if (!rx_en)
    begin
      st_nxt.rx_sync = 1'b0;
      st_nxt.rx_bit  = '0;
      st_nxt.rx_sh   = '0;
    end
    else if (!st_r.rx_sync && sync_fall)
      st_nxt.rx_sync = 1'b1;
    else if (st_r.rx_sync && sclk_rise)
    begin
      // Loopback feeds the transmit line straight back
      nbit = (diag == TSC_DM_LOOP) ? st_r.tx_line : rxd_s;
      st_nxt.rx_sh[msbf ? char_length_code - st_r.rx_bit : st_r.rx_bit] = nbit;
      if (st_r.rx_bit == char_length_code)
      begin
        // A full holding register gets overwritten; the older char is lost
        st_nxt.rx_ovf  = st_nxt.rx_ovf | st_nxt.rx_hv;
        st_nxt.rx_hold = st_nxt.rx_sh & char_mask;
        st_nxt.rx_hv   = 1'b1;
        st_nxt.rx_sh   = '0;
        st_nxt.rx_bit  = '0;
      end
      else
        st_nxt.rx_bit = st_r.rx_bit + 4'h1;
    end

    // Closing a receive descriptor
    if (rx_ok || rx_err)
    begin
      st_nxt.rx_act     = 1'b0;
      st_nxt.rx_ovf     = 1'b0;
      st_nxt.bd_len[rb] = rx_err || rx_ok && st_r.rx_hv && !mem_busy ? rcnt
                                                                      : st_r.rx_cnt;
      if (!st_r.bd_st[rb][`TSC_BD_CM] || rx_err)
        st_nxt.bd_st[rb][`TSC_BD_OWN] = 1'b0;
      if (rx_err)
        st_nxt.bd_st[rb][`TSC_BD_ERR] = 1'b1;
      if (st_r.bd_st[rb][`TSC_BD_I])
        st_nxt.evt[`TSC_EV_RX] = 1'b1;
      st_nxt.rx_cur = st_r.bd_st[rb][`TSC_BD_W] ? st_r.receive_table_base
                                                : st_r.rx_cur + 2'h1;
    end

    // Line output: echo returns received data, loopback keeps the pin idle
    case (diag)
      TSC_DM_ECHO: st_nxt.txd = rxd_s;
      TSC_DM_LOOP: st_nxt.txd = 1'b1;
      default:     st_nxt.txd = st_nxt.tx_line;
    endcase

    // Request stays up until every unmasked event is cleared
    st_nxt.irq = |(st_nxt.evt & st_r.mask);

    // Read data appear in the cycle after the strobe
    st_nxt.rdata = '0;
    if (rd_i)
    begin
      case (addr_i)
        `TSC_OFS_MODE:  st_nxt.rdata = {16'h0000, st_r.mode};
        `TSC_OFS_EVT:   st_nxt.rdata = {24'h000000, st_r.evt};
        `TSC_OFS_MASK:  st_nxt.rdata = {24'h000000, st_r.mask};
        `TSC_OFS_MRBL:  st_nxt.rdata = {16'h0000, st_r.mrbl};
        `TSC_OFS_RECEIVE_TABLE_BASE: st_nxt.rdata = {30'h0, st_r.receive_table_base};
        `TSC_OFS_TRANSMIT_TABLE_BASE: st_nxt.rdata = {30'h0, st_r.transmit_table_base};
        `TSC_OFS_STAT:  st_nxt.rdata = {20'h00000, st_r.rx_hv, st_r.rx_sync,
                                        st_r.rx_act, st_r.rx_cur, st_r.tx_hv,
                                        st_r.tx_act, st_r.tx_st, st_r.tx_cur,
                                        st_r.tx_shact};
        default:
        begin
          if (sw_bd && addr_i[3:2] == `TSC_FLD_ST)
            st_nxt.rdata = {16'h0000, st_r.bd_st[addr_i[6:4]]};
          else if (sw_bd && addr_i[3:2] == `TSC_FLD_LEN)
            st_nxt.rdata = {16'h0000, st_r.bd_len[addr_i[6:4]]};
          else if (sw_bd && addr_i[3:2] == `TSC_FLD_PTR)
            st_nxt.rdata = {25'h0, st_r.bd_ptr[addr_i[6:4]]};
          else if (sw_mem)
            st_nxt.rdata = {16'h0000, mem_q[addr_i[7:2]]};
        end
      endcase
    end
  end

  // State register; the line idles high from reset
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      st_r         <= '0;
      st_r.txd     <= 1'b1;
      st_r.tx_line <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // Buffer memory has no reset; software fills it before use
  always_ff @(posedge core_clk_i)
  begin
    if (mem_we)
      mem_q[mem_wa] <= mem_wd;
  end

  assign rdata_o = st_r.rdata;
  assign txd_o   = st_r.txd;
  assign irq_o   = st_r.irq;

endmodule // tsc_channel

// *** core/tsc_pin_sync.sv ***
// Brings serial clock, sync and receive data into the core clock domain
module tsc_pin_sync
  import tsc_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic sclk_i,
  input  wire logic sync_n_i,
  input  wire logic rxd_i,
  output logic      sclk_rise_o,
  output logic      sclk_fall_o,
  output logic      sync_fall_o,
  output logic      rxd_o
);

  tsc_pin_state_t st_r;
  tsc_pin_state_t st_nxt;

  // Two stages per pin, third stage only for edge finding on the stable copy
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.meta = {sclk_i, sync_n_i, rxd_i};
    st_nxt.stab = st_r.meta;
    st_nxt.prev = st_r.stab;
  end

  // Reset to each pin's idle level so no false edge follows release
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      st_r <= {`TSC_PIN_RST, `TSC_PIN_RST, `TSC_PIN_RST};
    else
      st_r <= st_nxt;
  end

  // Edges come from stable and previous stages only
  assign sclk_rise_o = st_r.stab[2] & ~st_r.prev[2];
  assign sclk_fall_o = ~st_r.stab[2] & st_r.prev[2];
  assign sync_fall_o = ~st_r.stab[1] & st_r.prev[1];
  assign rxd_o       = st_r.stab[0];

endmodule // tsc_pin_sync

// *** include/tsc_defs.svh ***
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// Register byte offsets on the plain register port
`define TSC_OFS_MODE      10'h000
`define TSC_OFS_EVT       10'h004
`define TSC_OFS_MASK      10'h008
`define TSC_OFS_MRBL      10'h00c
`define TSC_OFS_RECEIVE_TABLE_BASE     10'h010
`define TSC_OFS_TRANSMIT_TABLE_BASE     10'h014
`define TSC_OFS_CMD       10'h018
`define TSC_OFS_STAT      10'h01c

// Descriptor window: addr[9:7], entry addr[6:4], field addr[3:2]
`define TSC_BD_SEL        3'h1
`define TSC_FLD_ST        2'h0
`define TSC_FLD_LEN       2'h1
`define TSC_FLD_PTR       2'h2
// Buffer memory window: addr[9:8], word index addr[7:2]
`define TSC_MEM_SEL       2'h1

// Table sizes: entries 0..3 receive, 4..7 transmit
`define TSC_NBD           8
`define TSC_MEM_WORDS     64
`define TSC_RX_TABLE      1'b0
`define TSC_TX_TABLE      1'b1

// Mode control fields
`define TSC_MD_REN        0
`define TSC_MD_TEN        1
`define TSC_MD_DM         2
`define TSC_MD_SM         4
`define TSC_MD_MSB_FIRST_SELECT       10
`define TSC_MD_CHAR_LENGTH_CODE       11
`define TSC_MODE_WMASK    16'h7c3f
`define TSC_SM_TRANSP     2'h3
`define TSC_CHAR_LENGTH_CODE_BYTE_MAX 4'h7
`define TSC_CHAR_LENGTH_CODE_MAX      4'hf

// Descriptor status bits
`define TSC_BD_OWN        15
`define TSC_BD_W          13
`define TSC_BD_I          12
`define TSC_BD_L          11
`define TSC_BD_CM         9
`define TSC_BD_ERR        1

// Event and mask bits
`define TSC_EV_RX         0
`define TSC_EV_TX         1
`define TSC_EV_BSY        2
`define TSC_EV_TXE        4
`define TSC_EV_WMASK      8'h17

// Command register bits (write-only pulses)
`define TSC_CMD_HUNT      0
`define TSC_CMD_RESTART   1

// Misc
`define TSC_STEP_BYTE     16'h0001
`define TSC_STEP_WORD     16'h0002
`define TSC_ONES16        16'hffff
`define TSC_PIN_RST       3'h3  // Idle levels: serial clock low, sync and data high

`endif

// *** include/tsc_pkg.sv ***
package tsc_pkg;
  `include "tsc_defs.svh"

  typedef enum logic [1:0] {
    TSC_TX_OFF  = 2'b00,
    TSC_TX_WAIT = 2'b01,
    TSC_TX_RUN  = 2'b10,
    TSC_TX_HALT = 2'b11
  } tsc_tx_state_t;

  typedef enum logic [1:0] {
    TSC_DM_NORMAL = 2'b00,
    TSC_DM_LOOP   = 2'b01,
    TSC_DM_ECHO   = 2'b10,
    TSC_DM_RSVD   = 2'b11
  } tsc_diag_t;

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] stab;
    logic [2:0] prev;
  } tsc_pin_state_t;

  typedef struct packed {
    logic [15:0]                  mode;
    logic [7:0]                   evt;
    logic [7:0]                   mask;
    logic [15:0]                  mrbl;
    logic [1:0]                   receive_table_base;
    logic [1:0]                   transmit_table_base;
    logic [31:0]                  rdata;
    logic                         irq;
    logic                         txd;
    logic [`TSC_NBD-1:0][15:0]    bd_st;
    logic [`TSC_NBD-1:0][15:0]    bd_len;
    logic [`TSC_NBD-1:0][6:0]     bd_ptr;
    tsc_tx_state_t                tx_st;
    logic [1:0]                   tx_cur;
    logic                         tx_act;
    logic                         tx_last;
    logic [15:0]                  tx_cnt;
    logic [15:0]                  tx_hold;
    logic                         tx_hv;
    logic                         tx_hlast;
    logic [15:0]                  tx_sh;
    logic [3:0]                   tx_bit;
    logic                         tx_shact;
    logic                         tx_line;
    logic                         rx_sync;
    logic [15:0]                  rx_sh;
    logic [3:0]                   rx_bit;
    logic [15:0]                  rx_hold;
    logic                         rx_hv;
    logic                         rx_ovf;
    logic                         rx_act;
    logic [1:0]                   rx_cur;
    logic [15:0]                  rx_cnt;
  } tsc_state_t;
endpackage

// *** tb/tsc_channel_checker.sv ***
module tsc_channel_checker (
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire logic [9:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        sclk_i,
  input wire logic        sync_n_i,
  input wire logic        rxd_i,
  input wire logic        mem_wait_i,
  input wire logic        txd_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mode_r;
  logic [7:0]  mask_r;

  // Shadow of mode and mask as software wrote them; hardware never alters these
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      mode_r <= 16'h0;
      mask_r <= 8'h0;
    end
    else if (wr_i && addr_i == 10'h000)
      mode_r <= wdata_i[15:0];
    else if (wr_i && addr_i == 10'h008)
      mask_r <= wdata_i[7:0];
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  // Spacing of two cycles matches the bench's strobe tasks
  a_mode_readback: assert property (wr_i && addr_i == 10'h000 ##2
    rd_i && addr_i == 10'h000 |=> rdata_o == ($past(wdata_i, 3) & 32'h00007c3f))
    else $error("mode readback mismatch");
  a_mask_readback: assert property (wr_i && addr_i == 10'h008 ##2
    rd_i && addr_i == 10'h008 |=> rdata_o == ($past(wdata_i, 3) & 32'h00000017))
    else $error("mask readback mismatch");
  a_evt_reserved: assert property (rd_i && addr_i == 10'h004 |=>
    (rdata_o & ~32'h00000017) == 32'h0)
    else $error("reserved event bits set");
  a_zero_write: assert property (rd_i && addr_i == 10'h004 ##2
    wr_i && addr_i == 10'h004 && wdata_i[7:0] == 8'h00 ##2 rd_i && addr_i == 10'h004
    |=> (rdata_o & $past(rdata_o, 4)) == $past(rdata_o, 4))
    else $error("event cleared by zero write");
  a_masked_quiet: assert property ($past(mask_r) == 8'h00 |-> !irq_o)
    else $error("request with all masked");
  a_irq_hold: assert property (irq_o && !wr_i && !$past(wr_i) |=> irq_o)
    else $error("request dropped without write");
  a_off_idle: assert property (mode_r == 16'h0 && $past(mode_r, 3) == 16'h0 |-> txd_o)
    else $error("line active while off");
  a_loop_idle: assert property (mode_r[3:2] == 2'b01 && $past(mode_r, 3) == mode_r
    |-> txd_o)
    else $error("line active in loopback");
endmodule // tsc_channel_checker

bind tsc_channel tsc_channel_checker i_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sclk_i(sclk_i), .sync_n_i(sync_n_i),
  .rxd_i(rxd_i), .mem_wait_i(mem_wait_i), .txd_o(txd_o), .irq_o(irq_o)
);

// *** tb/tsc_channel_test.sv ***
module tsc_channel_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i, rstn_i, wr_i, rd_i, mem_wait_i;
  logic [9:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, v, ev;
  logic [63:0] rx;
  logic [7:0]  c0, c1;
  wire         sclk, sync_n, rxd, txd, irq;
  int          num_errors, num_checks, k;

  tsc_channel i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sclk_i(sclk),
    .sync_n_i(sync_n), .rxd_i(rxd), .mem_wait_i(mem_wait_i), .txd_o(txd), .irq_o(irq));
  tsc_far_end i_far (.sclk_o(sclk), .sync_n_o(sync_n), .rxd_o(rxd), .txd_i(txd));

  // Core clock, 100 MHz
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= {16'h0, d};
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample it there
  task automatic rchk(input logic [9:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hffffffff);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, rdata_o & m);
  endtask

  // Order of bits on the wire for two characters
  function automatic logic [15:0] wire_seq(input logic [7:0] a, input logic [7:0] b,
                                           input logic r);
    logic [15:0] s;
    for (int i = 0; i < 8; i++)
    begin
      s[i] = r ? a[7 - i] : a[i];
      s[8 + i] = r ? b[7 - i] : b[i];
    end
    return s;
  endfunction

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Cuts a hang short; the whole run needs a few thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    print_verdict;
  end

  // Main sequence
  initial
  begin
    {rstn_i, wr_i, rd_i, mem_wait_i, addr_i, wdata_i} = '0;
    void'($urandom(32'h1bf7));
    repeat (16) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rchk(10'h000, 32'h0);
    rchk(10'h004, 32'h0);
    rchk(10'h008, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      v = $urandom | 32'h4000; // Length code kept at 8 or more
      wr(10'h000, v[15:0] & 16'hfffc);
      rchk(10'h000, v & 32'h7c3c);
      wr(10'h008, v[15:0]);
      rchk(10'h008, v & 32'h17);
    end
    wr(10'h020, 16'hffff);
    rchk(10'h020, 32'h0);
    wr(10'h000, 16'h0);
    wr(10'h008, 16'h0017);
    wr(10'h00c, 16'h0001);
    for (int r = 0; r < 3; r++)
    begin
      c0 = $urandom & (r[0] ? 8'h7f : 8'hfe); // First bit on the wire is zero
      c1 = $urandom;
      rx = {$urandom, $urandom};
      wr(10'h120, {c0, c1});
      wr(10'h0c4, 16'h0002);
      wr(10'h0c8, 16'h0010); // Even pointer
      wr(10'h0c0, 16'hb800);
      wr(10'h080, 16'hb000);
      wr(10'h004, 16'h00ff);
      wr(10'h000, {1'b0, 4'h7, r[0], 10'h033});
      ev = (r == 2) ? 32'h11 : 32'h7;
      // Round 2 starves the memory port once the first char is held
      fork
        i_far.frame(rx, 64);
        begin
          repeat (8) @(posedge core_clk_i);
          mem_wait_i <= (r == 2);
        end
      join
      @(posedge core_clk_i);
      mem_wait_i <= 1'b0;
      repeat (20) @(posedge core_clk_i);
      k = 0;
      while (k < 48 && i_far.seen[k] === 1'b1) k++;
      chk("tx wire", wire_seq(c0, (r == 2) ? 8'hff : c1, r[0]), i_far.seen[k +: 16]);
      rchk(10'h0c0, (r == 2) ? 32'h3802 : 32'h3800);
      rchk(10'h080, (r == 2) ? 32'h3002 : 32'h3000);
      rchk(10'h084, 32'h1);
      v = wire_seq((r == 2) ? rx[63:56] : rx[7:0], 8'h00, r[0]); // Overrun keeps newest
      rchk(10'h100, {v[7:0], 8'h00}, 32'hff00);
      rchk(10'h004, ev);
      wr(10'h004, 16'h0);
      rchk(10'h004, ev);
      chk("irq", 32'h1, irq);
      wr(10'h004, 16'h0002);
      rchk(10'h004, ev & ~32'h2);
      wr(10'h004, 16'h00ff);
      repeat (2) @(posedge core_clk_i);
      #1;
      chk("irq", 32'h0, irq);
      wr(10'h000, 16'h0);
      repeat (30) @(posedge core_clk_i);
    end
    wr(10'h000, 16'h3837);
    repeat (20) @(posedge core_clk_i);
    #1;
    chk("loopback txd", 32'h1, txd);
    // Leave the far data line low, then echo must copy it to the pin
    i_far.frame(64'h1, 1);
    wr(10'h000, 16'h383b);
    repeat (20) @(posedge core_clk_i);
    #1;
    chk("echo txd", 32'h0, txd);
    print_verdict;
  end
endmodule // tsc_channel_test

// *** tb/tsc_far_end.sv ***
// Remote serial end: makes frames, sends data and records the line back
module tsc_far_end (
  output logic      sclk_o,
  output logic      sync_n_o,
  output logic      rxd_o,
  input  wire logic txd_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] seen;

  // Serial clock stands low outside frames
  initial
  begin
    sclk_o = 1'b0;
    sync_n_o = 1'b1;
    rxd_o = 1'b1;
  end

  // Sync fall opens the frame; data changes on fall, line sampled before next fall
  // Starts 2 ns off the core edge so pins never move on a sampling edge
  task automatic frame(input logic [63:0] d, input int n);
    #2 sync_n_o = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      rxd_o = d[i];
      #40 sclk_o = 1'b1;
      #40 seen[i] = txd_i;
      sclk_o = 1'b0;
    end
    sync_n_o = 1'b1;
    rxd_o = ~rxd_o; // Released line must not look like held data
  endtask
endmodule // tsc_far_end
